// ---- adc_seq_pkg.sv ----
package adc_seq_pkg;
  localparam int NUM_SEQ    = 4;
  localparam int DEPTH_SEQ0 = 8;
  localparam int DEPTH_SEQ1 = 4;
  localparam int DEPTH_SEQ2 = 4;
  localparam int DEPTH_SEQ3 = 1;
  localparam int WORD_W     = 32;
  localparam int RESULT_W   = 10;
  localparam int NIB_W      = 4;
  localparam int ACC_W      = 16;
  // Control nibble field positions and the temperature channel code.
  localparam int CTL_DIFF_BIT = 0;
  localparam int CTL_END_BIT  = 1;
  localparam int CTL_IE_BIT   = 2;
  localparam int CTL_TEMP_BIT = 3;
  localparam logic [3:0] TEMP_CHANNEL = 4'h8;
  // Trigger source encodings.
  localparam logic [1:0] TRIG_SOFTWARE = 2'h0;
  localparam logic [1:0] TRIG_TIMER    = 2'h1;
  localparam logic [1:0] TRIG_GPIO     = 2'h2;
  localparam logic [1:0] TRIG_ALWAYS   = 2'h3;
  // Reset values of the configuration straps and the averaging cap.
  localparam logic [2:0] AVG_RESET = 3'h0;
  localparam logic [2:0] AVG_MAX   = 3'h6;
  localparam logic [7:0] PRI_RESET = 8'he4;

  typedef struct packed {
    logic       full;
    logic       empty;
    logic [3:0] head;
    logic [3:0] tail;
  } fifo_status_s;

  typedef struct packed {
    logic [3:0] channel;
    logic       diff;
  } conv_req_s;
endpackage

// ---- result_fifo.sv ----
module result_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output adc_seq_pkg::fifo_status_s status
);
  import adc_seq_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [PW:0]      count_reg;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
    advance = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  assign inReady  = (count_reg != DEPTH_CNT);
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign status   = '{full: !inReady, empty: !outValid,
                      head: 4'(rdPtr_reg), tail: 4'(wrPtr_reg)};

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) wrPtr_reg <= advance(wrPtr_reg);
      if (doRead) rdPtr_reg <= advance(rdPtr_reg);
      count_reg <= count_reg + (PW + 1)'(doWrite) - (PW + 1)'(doRead);
    end
  end
endmodule

// ---- adc_sample_sequencer_control.sv ----
// How it works
// - Sequencers hold 8, 4, 4, 1 steps and words.
// - FIFO words are 32 bits, result in low 10.
// - Each step: input nibble plus control nibble.
// - Triggers count only while the sequencer is active.
// - The same input may repeat within one sequence.
// - Interrupt raised after each step with enable set.
// - End flag stops the sequence after that step.
// - Each FIFO is circular; a read pops the oldest.
// - Status shows head, tail, full and empty.
// - Overflow and underflow are recorded per sequencer.
// - Eight external inputs plus temperature sensor, 10-bit.
// - Per-sequencer source, trigger, interrupt and priority.
// - Averaging accumulates up to 64 conversions.
// - Sequencing keeps pace with one million samples per second.
// - Triggered steps run back to back unattended.
// - Priority 0 is highest, 3 lowest, all unique.
// - Writing one clears an interrupt; mask gates it.
// - Differential pair k samples inputs 2k and 2k+1.
// - Averaging is off after reset.
module adc_sample_sequencer_control (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              activeSequencerEnables,
  input  wire logic [3:0][31:0]        stepInputSelect,
  input  wire logic [3:0][31:0]        stepControlNibbles,
  input  wire logic [7:0]              sequencerPriority,
  input  wire logic [3:0][1:0]         triggerSelect,
  input  wire logic [3:0]              swTrigger,
  input  wire logic                    timerTrigger,
  input  wire logic                    gpioTrigger,
  input  wire logic [2:0]              averagingControl,
  input  wire logic [3:0]              irqMask,
  input  wire logic [3:0]              irqStatusClear,
  input  wire logic [3:0]              overflowClear,
  input  wire logic [3:0]              underflowClear,
  output logic                         convStart,
  output adc_seq_pkg::conv_req_s       convReq,
  input  wire logic                    convDone,
  input  wire logic [9:0]              convResult,
  input  wire logic [3:0]              resultPop,
  output logic [31:0]                  resultData,
  output adc_seq_pkg::fifo_status_s [3:0] fifoStatus,
  output logic [3:0]                   fifoOverflowStatus,
  output logic [3:0]                   fifoUnderflowStatus,
  output logic [3:0]                   rawIrqStatus,
  output logic [3:0]                   irqStatus,
  output logic                         busy
);
  import adc_seq_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  typedef enum logic [4:0] {
    IDLE  = 5'h01,
    LOAD  = 5'h02,
    ISSUE = 5'h04,
    WAIT  = 5'h08,
    PUSH  = 5'h10
  } seq_state_e;

  seq_state_e       state_reg, state_next;
  logic [3:0]       pending_reg;
  logic [1:0]       curSeq_reg;
  logic [2:0]       stepIdx_reg;
  logic [5:0]       avgCnt_reg;
  logic [ACC_W-1:0] acc_reg;
  logic [9:0]       avgResult_reg;
  conv_req_s        convReq_reg;
  logic [31:0]      resultData_reg;
  logic [3:0]       overflow_reg;
  logic [3:0]       underflow_reg;
  logic [3:0]       rawIrq_reg;

  function automatic logic [2:0] lastStep(input logic [1:0] s);
    unique case (s)
      2'd0:    lastStep = 3'(DEPTH_SEQ0 - 1);
      2'd1:    lastStep = 3'(DEPTH_SEQ1 - 1);
      2'd2:    lastStep = 3'(DEPTH_SEQ2 - 1);
      default: lastStep = 3'(DEPTH_SEQ3 - 1);
    endcase
  endfunction

  function automatic logic [3:0] nibble(input logic [31:0] w,
                                        input logic [2:0]  i);
    nibble = w[{i, 2'b00} +: 4];
  endfunction

  function automatic logic [1:0] prio(input logic [1:0] s);
    prio = sequencerPriority[{s, 1'b0} +: 2];
  endfunction

  // Pick the pending sequencer holding the smallest priority value.
  function automatic logic [1:0] winner(input logic [3:0] p);
    logic [1:0] w;
    logic       found;
    w = 2'd0;
    found = 1'b0;
    for (int i = 0; i < NUM_SEQ; i++) begin
      if (p[i] && (!found || prio(2'(i)) < prio(w))) begin
        w = 2'(i);
        found = 1'b1;
      end
    end
    winner = w;
  endfunction

  // Trigger decode and pending latch.
  logic [3:0] trigHit;
  always_comb begin
    for (int i = 0; i < NUM_SEQ; i++) begin
      unique case (triggerSelect[i])
        TRIG_SOFTWARE: trigHit[i] = swTrigger[i];
        TRIG_TIMER:    trigHit[i] = timerTrigger;
        TRIG_GPIO:     trigHit[i] = gpioTrigger;
        TRIG_ALWAYS:   trigHit[i] = 1'b1;
      endcase
    end
  end

  wire        anyPending = |pending_reg;
  wire [1:0]  pickSeq    = winner(pending_reg);
  wire        startSeq   = (state_reg == IDLE) && anyPending;
  wire [3:0]  pendClr    = startSeq ? 4'(1) << pickSeq : 4'h0;
  wire [3:0]  pendNext   = ((pending_reg & ~pendClr) | trigHit)
                           & activeSequencerEnables;

  // Step decode for the current step.
  wire [3:0] muxNib = nibble(stepInputSelect[curSeq_reg], stepIdx_reg);
  wire [3:0] ctlNib = nibble(stepControlNibbles[curSeq_reg], stepIdx_reg);
  wire       stepDiff = ctlNib[CTL_DIFF_BIT];
  wire       stepEnd  = ctlNib[CTL_END_BIT];
  wire       stepIe   = ctlNib[CTL_IE_BIT];
  wire       stepTemp = ctlNib[CTL_TEMP_BIT];
  wire       lastOne  = stepEnd || (stepIdx_reg == lastStep(curSeq_reg));
  // Repeated inputs need no check; every step decodes on its own.
  conv_req_s stepReq;
  assign stepReq.diff    = stepDiff;
  assign stepReq.channel = stepTemp ? TEMP_CHANNEL :
                           stepDiff ? {1'b0, muxNib[1:0], 1'b0} :
                                      {1'b0, muxNib[2:0]};

  // Averaging: 2^n conversions per stored word, n capped at six.
  wire [2:0] avgShift = (averagingControl > AVG_MAX) ? AVG_MAX
                                                     : averagingControl;
  wire [5:0] avgLast  = 6'((7'd1 << avgShift) - 7'd1);
  wire [ACC_W-1:0] accSum = acc_reg + ACC_W'(convResult);
  wire [ACC_W-1:0] accAvg = accSum >> avgShift;
  wire       avgDone  = (avgCnt_reg == avgLast);

  // Result FIFOs, one per sequencer.
  logic [3:0]       fifoInValid, fifoInReady, fifoOutValid;
  logic [3:0][31:0] fifoOutData;
  wire  [31:0]      pushWord = {22'h0, avgResult_reg};
  wire              pushing  = (state_reg == PUSH);
  wire              pushOk   = pushing && fifoInReady[curSeq_reg];
  assign fifoInValid = pushing ? 4'(1) << curSeq_reg : 4'h0;

  for (genvar g = 0; g < NUM_SEQ; g++) begin : g_fifo
    localparam int D = (g == 0) ? DEPTH_SEQ0 : (g == 1) ? DEPTH_SEQ1 :
                       (g == 2) ? DEPTH_SEQ2 : DEPTH_SEQ3;
    result_fifo #(.WIDTH(WORD_W), .DEPTH(D)) u_fifo (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .inValid  (fifoInValid[g]),
      .inReady  (fifoInReady[g]),
      .inData   (pushWord),
      .outValid (fifoOutValid[g]),
      .outReady (resultPop[g]),
      .outData  (fifoOutData[g]),
      .status   (fifoStatus[g])
    );
  end

  // Sequencer state machine: steps follow without software help.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE:  if (anyPending) state_next = LOAD;
      LOAD:  state_next = ISSUE;
      ISSUE: state_next = WAIT;
      WAIT:  if (convDone) state_next = avgDone ? PUSH : ISSUE;
      PUSH:  if (pushOk) state_next = lastOne ? IDLE : LOAD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= IDLE;
      pending_reg <= 4'h0;
    end else begin
      state_reg   <= state_next;
      pending_reg <= pendNext;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      curSeq_reg  <= 2'd0;
      stepIdx_reg <= 3'd0;
    end else if (startSeq) begin
      curSeq_reg  <= pickSeq;
      stepIdx_reg <= 3'd0;
    end else if (pushOk && !lastOne) begin
      stepIdx_reg <= stepIdx_reg + 3'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg       <= '0;
      avgCnt_reg    <= 6'd0;
      avgResult_reg <= 10'h0;
      convReq_reg   <= '0;
    end else if (state_reg == LOAD) begin
      acc_reg     <= '0;
      avgCnt_reg  <= 6'd0;
      convReq_reg <= stepReq;
    end else if (state_reg == WAIT && convDone) begin
      acc_reg    <= accSum;
      avgCnt_reg <= avgCnt_reg + 6'd1;
      if (avgDone) avgResult_reg <= accAvg[9:0];
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle.
  wire [3:0] irqSet   = (pushOk && stepIe) ? 4'(1) << curSeq_reg : 4'h0;
  wire [3:0] ovfSet   = (pushing && !pushOk) ? 4'(1) << curSeq_reg
                                             : 4'h0;
  wire [3:0] undSet   = resultPop & ~fifoOutValid;
  wire [3:0] popWin   = resultPop & fifoOutValid;
  wire [1:0] popSel   = popWin[0] ? 2'd0 : popWin[1] ? 2'd1 :
                        popWin[2] ? 2'd2 : 2'd3;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rawIrq_reg     <= 4'h0;
      overflow_reg   <= 4'h0;
      underflow_reg  <= 4'h0;
      resultData_reg <= 32'h0;
    end else begin
      rawIrq_reg    <= (rawIrq_reg & ~irqStatusClear) | irqSet;
      overflow_reg  <= (overflow_reg & ~overflowClear) | ovfSet;
      underflow_reg <= (underflow_reg & ~underflowClear) | undSet;
      if (|popWin) resultData_reg <= fifoOutData[popSel];
    end
  end

  assign convStart           = (state_reg == ISSUE);
  assign convReq             = convReq_reg;
  assign resultData          = resultData_reg;
  assign fifoOverflowStatus  = overflow_reg;
  assign fifoUnderflowStatus = underflow_reg;
  assign rawIrqStatus        = rawIrq_reg;
  assign irqStatus           = rawIrq_reg & irqMask;
  assign busy                = (state_reg != IDLE);

  sequence s_load_issue;
    (state_reg == LOAD) ##1 convStart ##1 (state_reg == WAIT);
  endsequence

  property p_inactive_ignored;
    !activeSequencerEnables[0] |=> !pending_reg[0];
  endproperty
  a_inactive_ignored: assert property (p_inactive_ignored)
    else $error("Inactive sequencer kept a pending trigger.");

  property p_step_issue;
    (state_reg == LOAD) |-> s_load_issue;
  endproperty
  a_step_issue: assert property (p_step_issue)
    else $error("Step did not issue a conversion after loading.");

  property p_avg_off_pass;
    (averagingControl == 3'h0 && state_reg == WAIT && convDone)
      |=> pushing ##0 (pushWord[9:0] == $past(convResult));
  endproperty
  a_avg_off_pass: assert property (p_avg_off_pass)
    else $error("Unaveraged result not pushed unchanged.");

  property p_word_upper_zero;
    (|popWin) |=> (resultData[31:10] == 22'h0);
  endproperty
  a_word_upper_zero: assert property (p_word_upper_zero)
    else $error("Result word upper bits not zero.");

  property p_irq_after_step;
    (pushOk && stepIe) |=> rawIrqStatus[$past(curSeq_reg)];
  endproperty
  a_irq_after_step: assert property (p_irq_after_step)
    else $error("Step interrupt not raised.");

  property p_end_stops;
    (pushOk && stepEnd) |=> (state_reg == IDLE);
  endproperty
  a_end_stops: assert property (p_end_stops)
    else $error("Sequence ran past its end step.");

  property p_overflow_flag;
    (pushing && !pushOk) |=> fifoOverflowStatus[$past(curSeq_reg)];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag)
    else $error("Overflow not flagged on a full FIFO.");

  property p_underflow_flag;
    (resultPop[3] && fifoStatus[3].empty) |=> fifoUnderflowStatus[3];
  endproperty
  a_underflow_flag: assert property (p_underflow_flag)
    else $error("Underflow not flagged on an empty read.");

  property p_irq_clear;
    (irqStatusClear[0] && irqSet[0] == 1'b0) |=> !rawIrqStatus[0];
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("Interrupt not cleared by writing one.");

  property p_priority_pick;
    (startSeq && pending_reg[0] && prio(2'd0) == 2'd0)
      |=> (curSeq_reg == 2'd0);
  endproperty
  a_priority_pick: assert property (p_priority_pick)
    else $error("Highest priority pending sequencer not served.");

  property p_conv_pulse;
    convStart |=> !convStart;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse)
    else $error("Conversion start lasted more than one cycle.");

  // An idle block starts converting a fresh trigger three edges later.
  property p_trigger_latency;
    (|(trigHit & activeSequencerEnables) && !busy && !anyPending)
      |-> ##3 convStart;
  endproperty
  a_trigger_latency: assert property (p_trigger_latency)
    else $error("Idle trigger did not start a conversion in time.");

  property p_pop_advances;
    (resultPop[0] && !fifoStatus[0].empty) |=> $changed(fifoStatus[0].head);
  endproperty
  a_pop_advances: assert property (p_pop_advances)
    else $error("Read of a filled FIFO did not advance its head.");
endmodule

// ---- conv_model.sv ----
module conv_model (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   convStart,
  input  wire adc_seq_pkg::conv_req_s convReq,
  input  wire logic [3:0]             delay,
  output logic                        convDone,
  output logic [9:0]                  convResult
);
  timeunit 1ns;
  timeprecision 100ps;
  import adc_seq_pkg::*;
  logic       running;
  logic [3:0] cnt;
  logic [9:0] held;

  // Outside a done pulse the result lines toggle, so nothing stale is read.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      running    <= 1'b0;
      cnt        <= 4'h0;
      held       <= 10'h000;
      convDone   <= 1'b0;
      convResult <= 10'h000;
    end else begin
      convDone   <= 1'b0;
      convResult <= ~convResult;
      if (convStart) begin
        running <= 1'b1;
        cnt     <= delay;
        held    <= {convReq.diff, convReq.channel, 5'h15};
      end else if (running) begin
        if (cnt == 4'h0) begin
          running    <= 1'b0;
          convDone   <= 1'b1;
          convResult <= held;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule

// ---- adc_sample_sequencer_control_test.sv ----
module adc_sample_sequencer_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_seq_pkg::*;
  logic               sys_clk, rst_n, timerTrigger, gpioTrigger;
  logic               convStart, convDone, busy;
  logic [3:0]         activeSequencerEnables, swTrigger, irqMask;
  logic [3:0]         irqStatusClear, overflowClear, underflowClear;
  logic [3:0]         resultPop, fifoOverflowStatus, fifoUnderflowStatus;
  logic [3:0]         rawIrqStatus, irqStatus, delay;
  logic [3:0][31:0]   stepInputSelect, stepControlNibbles;
  logic [3:0][1:0]    triggerSelect;
  logic [7:0]         sequencerPriority;
  logic [2:0]         averagingControl;
  logic [9:0]         convResult;
  logic [31:0]        resultData;
  conv_req_s          convReq;
  fifo_status_s [3:0] fifoStatus;
  int                 errors, checked, starts, seed;
  logic [3:0]         seenCh[$];

  adc_sample_sequencer_control adc_sample_sequencer_control_inst (
    .sys_clk, .rst_n, .activeSequencerEnables, .stepInputSelect,
    .stepControlNibbles, .sequencerPriority, .triggerSelect, .swTrigger,
    .timerTrigger, .gpioTrigger, .averagingControl, .irqMask,
    .irqStatusClear, .overflowClear, .underflowClear, .convStart, .convReq,
    .convDone, .convResult, .resultPop, .resultData, .fifoStatus,
    .fifoOverflowStatus, .fifoUnderflowStatus, .rawIrqStatus, .irqStatus,
    .busy);
  conv_model conv_model_inst (.sys_clk, .rst_n, .convStart, .convReq,
    .delay, .convDone, .convResult);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (convStart === 1'b1) begin
      starts++;
      seenCh.push_back(convReq.channel);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] expWord(logic [3:0] nib, logic [3:0] c);
    logic [3:0] ch;
    ch = c[CTL_TEMP_BIT] ? TEMP_CHANNEL :
         c[CTL_DIFF_BIT] ? {nib[2:0], 1'b0} : nib;
    return {22'h0, c[CTL_DIFF_BIT], ch, 5'h15};
  endfunction

  task automatic wait_idle();
    int q;
    q = 0;
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 5000 && q < 3; k++) begin
      @(posedge sys_clk);
      #1 q = (busy === 1'b0) ? q + 1 : 0;
    end
    check(q, 3);
  endtask

  task automatic kick(input logic [3:0] sw, input logic t, input logic g);
    @(posedge sys_clk);
    swTrigger    <= sw;
    timerTrigger <= t;
    gpioTrigger  <= g;
    @(posedge sys_clk);
    swTrigger    <= 4'h0;
    timerTrigger <= 1'b0;
    gpioTrigger  <= 1'b0;
    wait_idle();
  endtask

  task automatic prog(input int s, input logic [31:0] i, input logic [31:0] c);
    @(posedge sys_clk);
    activeSequencerEnables[s] <= 1'b0;
    stepInputSelect[s]        <= i;
    stepControlNibbles[s]     <= c;
    @(posedge sys_clk) activeSequencerEnables[s] <= 1'b1;
  endtask

  task automatic pop(input int s, input logic [31:0] exp);
    @(posedge sys_clk) resultPop <= 4'(1 << s);
    @(posedge sys_clk) resultPop <= 4'h0;
    #1 check(resultData, exp);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // The whole run needs under two thousand cycles; this leaves ample margin.
  initial begin
    #(40000 * 25);
    errors++;
    end_of_test();
  end

  initial begin
    int n, kind, s0;
    logic m, anyIe;
    logic [3:0] nib, c;
    logic [31:0] inp, ctl, exp[8];
    logic [7:0] prs[2];
    logic [2:0] avg[2];
    prs = '{8'he4, 8'h4b};
    avg = '{3'h2, 3'h7};
    seed = 32'h1fa7;
    {rst_n, timerTrigger, gpioTrigger, swTrigger, irqMask} = '0;
    {activeSequencerEnables, irqStatusClear, resultPop, delay} = '0;
    {overflowClear, underflowClear, stepInputSelect} = '0;
    {stepControlNibbles, triggerSelect} = '0;
    sequencerPriority = PRI_RESET;
    averagingControl  = AVG_RESET;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    for (int s = 0; s < 4; s++) check(fifoStatus[s], 10'h100);
    check({fifoOverflowStatus, fifoUnderflowStatus, rawIrqStatus}, 0);
    for (int r = 0; r < 4; r++) begin
      n = (r == 0) ? 8 : $unsigned($random(seed)) % 8 + 1;
      {inp, ctl, anyIe} = '0;
      for (int k = 0; k < n; k++) begin
        kind = $unsigned($random(seed)) % 4;
        nib = 4'($unsigned($random(seed)) % 8);
        if (kind == 3 && k > 0) nib = inp[4*k-4 +: 4];
        if (kind == 1) nib[3:2] = 2'h0;
        c = 4'h0;
        c[CTL_IE_BIT] = 1'($random(seed));
        c[CTL_TEMP_BIT] = (kind == 2);
        c[CTL_DIFF_BIT] = (kind == 1);
        c[CTL_END_BIT] = (k == n - 1);
        inp[4*k +: 4] = nib;
        ctl[4*k +: 4] = c;
        anyIe |= c[CTL_IE_BIT];
        exp[k] = expWord(nib, c);
      end
      m = 1'($random(seed));
      @(posedge sys_clk);
      delay   <= 4'($unsigned($random(seed)) % 4);
      irqMask <= {3'h0, m};
      prog(0, inp, ctl);
      s0 = starts;
      kick(4'h1, 1'b0, 1'b0);
      check(starts - s0, n);
      check(rawIrqStatus[0], anyIe);
      check(irqStatus[0], anyIe & m);
      check(fifoStatus[0].full, n == 8);
      for (int k = 0; k < n; k++) pop(0, exp[k]);
      check(fifoStatus[0].empty, 1);
      @(posedge sys_clk) irqStatusClear <= 4'h1;
      @(posedge sys_clk) irqStatusClear <= 4'h0;
      #1 check(rawIrqStatus[0], 0);
    end
    for (int t = 0; t < 2; t++) begin
      @(posedge sys_clk) sequencerPriority <= prs[t];
      for (int s = 0; s < 4; s++) prog(s, s, 32'h2);
      seenCh.delete();
      kick(4'hf, 1'b0, 1'b0);
      for (int p = 0; p < 4; p++)
        for (int s = 0; s < 4; s++)
          if (prs[t][2*s +: 2] == p) check(seenCh[p], s);
      for (int s = 0; s < 4; s++) pop(s, expWord(4'(s), 4'h2));
    end
    @(posedge sys_clk) activeSequencerEnables <= 4'h0;
    s0 = starts;
    kick(4'h2, 1'b0, 1'b0);
    check(starts - s0, 0);
    check(fifoStatus[1].empty, 1);
    prog(1, 32'h5, 32'h2);
    prog(2, 32'h6, 32'h2);
    @(posedge sys_clk) triggerSelect <= {TRIG_SOFTWARE, TRIG_GPIO,
                                         TRIG_TIMER, TRIG_SOFTWARE};
    kick(4'h0, 1'b1, 1'b0);
    check(seenCh[$], 5);
    kick(4'h0, 1'b0, 1'b1);
    check(seenCh[$], 6);
    pop(1, expWord(4'h5, 4'h2));
    pop(2, expWord(4'h6, 4'h2));
    @(posedge sys_clk) triggerSelect <= '0;
    prog(3, 32'h7, 32'h2);
    kick(4'h8, 1'b0, 1'b0);
    check(fifoStatus[3].full, 1);
    @(posedge sys_clk) triggerSelect[3] <= TRIG_ALWAYS;
    @(posedge sys_clk) triggerSelect[3] <= TRIG_SOFTWARE;
    repeat (20) @(posedge sys_clk);
    #1 check(fifoOverflowStatus, 4'h8);
    pop(3, expWord(4'h7, 4'h2));
    wait_idle();
    pop(3, expWord(4'h7, 4'h2));
    @(posedge sys_clk) overflowClear <= 4'h8;
    @(posedge sys_clk) overflowClear <= 4'h0;
    #1 check(fifoOverflowStatus, 0);
    pop(3, expWord(4'h7, 4'h2));
    check(fifoUnderflowStatus, 4'h8);
    check(fifoStatus[3].head, fifoStatus[3].tail);
    @(posedge sys_clk) underflowClear <= 4'h8;
    @(posedge sys_clk) underflowClear <= 4'h0;
    #1 check(fifoUnderflowStatus, 0);
    for (int a = 0; a < 2; a++) begin
      @(posedge sys_clk) averagingControl <= avg[a];
      s0 = starts;
      kick(4'h8, 1'b0, 1'b0);
      check(starts - s0, 1 << ((avg[a] > 6) ? 6 : avg[a]));
      pop(3, expWord(4'h7, 4'h2));
    end
    end_of_test();
  end
endmodule
